// file: fpc_flash_ctrl.sv
/*
 * Flash erase/program controller: command and page registers, sector
 * guard, option-byte limits, program and erase sequencing.
 * Assumes a flash array that acts on flash_cmd_out while it is held and
 * returns the addressed byte combinationally on flash_rdata_in.
 */
// Notes on behaviour
// - programming port ignores sector guard
// - option protect bits override normal flow
// - option bits block external main, info3
// - sectors of sixteen 512-byte pages
// - 5EH while locked redirects next 02H
// - sector guard resets to zero
// - guarded sector refuses CPU program/erase
// - guard bits sticky until power down
// - CPU programs main only; port also info3
// - erase scope decides programmable locations
// - erase gives FFH; program clears bits
// - CPU stalled during its operations
// - other commands end programming and relock
// - 95H erases selected unguarded page
// - port done bit; relock after erase
// - CPU no info access; port via bit7
// - 63H mass erase, port only, main
// - unlock needs 73H then 8CH
// - invalid command or order relocks
// - command write, status read, same address
// - page writes bracket unlock, must match
// - reset enters locked state
// - page bits match address bits 15:9
`timescale 1ns/10ps
module fpc_flash_ctrl
  import fpc_pkg::*;
#(
  parameter int unsigned ERASE_CYCLES = ERASE_CYC
)
(
  input  wire logic           clk_in,
  input  wire logic           rstn_in,
  input  wire logic           reg_wr_in,
  input  wire logic           reg_rd_in,
  input  wire fpc_reg_wr_t    reg_req_in,
  output logic [7:0]          reg_rdata_out,
  input  wire logic           prog_req_in,
  input  wire fpc_prog_req_t  prog_in,
  input  wire logic           opt_rw_prot_in,
  input  wire logic           opt_low_prot_in,
  input  wire logic [7:0]     flash_rdata_in,
  output fpc_flash_cmd_t      flash_cmd_out,
  output logic                cpu_stall_out,
  output logic [7:0]          icp_status_out,
  output logic                ext_main_rd_block_out,
  output logic                ext_low_rd_block_out
);
  logic           rst_s1_reg;
  logic           rst_s2_reg;
  logic [7:0]     page_pointer_reg;
  logic [7:0]     page_pointer_next;
  logic [7:0]     sector_write_guard;
  logic [7:0]     sector_write_guard_next;
  fpc_scope_t     scope_reg;
  fpc_scope_t     scope_next;
  logic           mass_done_reg;
  logic           icp_done_reg;
  logic           icp_done_next;
  logic           refused_reg;
  logic           refused_next;
  logic           op_icp_reg;
  fpc_flash_cmd_t flash_cmd_reg;
  fpc_flash_cmd_t flash_cmd_next;
  logic [7:0]     rdata_next;
  fpc_lock_t      lock_state;
  logic           busy;
  logic           done;
  logic           start;
  logic [TMR_W-1:0] tmr_load;

  // sixteen pages per sector
  // a sector guard bit covers page bits 6:4
  function automatic logic guarded(input logic [7:0] guard,
                                   input logic [6:0] page);
    guarded = guard[page[6:SECTOR_LSB]];
  endfunction

  // low half blocked by one option bit, all of main by the other
  function automatic logic ext_blocked(input logic rw, input logic low,
                                       input logic [6:0] page);
    ext_blocked = rw || (low && !page[6]);
  endfunction

  // reset release through two flops
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  wire        rst_n      = rst_s2_reg;
  // writes during an operation are dropped
  wire        wr_ok      = reg_wr_in && !busy;
  wire        cmd_wr     = wr_ok && reg_req_in.addr == ADDR_CMD;
  wire        at_page    = wr_ok && reg_req_in.addr == ADDR_PAGE;
  wire [7:0]  wdata      = reg_req_in.data;
  wire        from_icp   = reg_req_in.in_circuit_prog_port;
  wire        unlocked   = (lock_state == ST_UNLOCKED);
  wire        guard_wr   = at_page && lock_state == ST_SEC_ARMED;
  wire        page_wr    = at_page && !guard_wr;
  wire [6:0]  sel_page   = page_pointer_reg[6:0];
  wire        sel_info   = page_pointer_reg[INFO_SEL_BIT];
  // protection lifts only after a mass erase this power-up
  wire        prot_any   = (opt_rw_prot_in || opt_low_prot_in) &&
                           !mass_done_reg;
  wire        prot_rw    = opt_rw_prot_in && !mass_done_reg;
  wire        prot_low   = opt_low_prot_in && !mass_done_reg;

  // option bits checked ahead of the normal flow
  wire        ext_main_ok = !ext_blocked(prot_rw, prot_low, sel_page);
  // info erase only for page 3 from the port
  wire        info_ok     = page_pointer_reg == PAGE_INFO3 && !prot_any;
  // port skips the guard, CPU honours it
  // erase needs unlocked and a valid page
  wire        perase_ok = unlocked && (from_icp ?
                (sel_info ? info_ok : ext_main_ok) :
                (!sel_info && !guarded(sector_write_guard, sel_page)));
  wire        perase_go = cmd_wr && wdata == CMD_PAGE_ERASE && perase_ok;
  // mass erase from the port only
  // while unlocked, a CPU mass erase only sets the refused bit
  wire        merase_go = cmd_wr && wdata == CMD_MASS_ERASE && unlocked &&
                          from_icp;
  wire        erase_bad = cmd_wr && unlocked && !perase_go && !merase_go &&
                          (wdata == CMD_PAGE_ERASE ||
                           wdata == CMD_MASS_ERASE);

  wire        main_match = prog_in.addr[15:PAGE_ADDR_LSB] == sel_page;
  wire        info_match = prog_in.addr[12:INFO_ADDR_LSB] == sel_page;
  // scope widened by main page and mass erases, never narrowed
  wire        scope_ok   = scope_reg == SCOPE_ALL ||
                           (scope_reg == SCOPE_PAGE && main_match);
  // CPU main only, port main or info3
  // match needed after mass erase too
  wire        prog_main  = !prog_in.info && !sel_info && scope_ok &&
                           main_match &&
                           (prog_in.in_circuit_prog_port ?
                            !ext_blocked(prot_rw, prot_low,
                                         prog_in.addr[15:PAGE_ADDR_LSB]) :
                            !guarded(sector_write_guard,
                                     prog_in.addr[15:PAGE_ADDR_LSB]));
  wire        prog_info  = prog_in.info && prog_in.in_circuit_prog_port && info_match &&
                           page_pointer_reg == PAGE_INFO3 && !prot_any;
  wire        prog_take  = prog_req_in && !busy && unlocked;
  wire        prog_go    = prog_take && (prog_main || prog_info);
  wire        prog_bad   = prog_take && !prog_go;
  wire        erase_done = done && !flash_cmd_reg.prog;

  assign start = prog_go || perase_go || merase_go;
  assign tmr_load = prog_go ? TMR_W'(PROG_CYC) : TMR_W'(ERASE_CYCLES);

  fpc_unlock_seq u_lock (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .cmd_wr_in   (cmd_wr && !perase_go && !merase_go && !erase_bad),
    .page_wr_in  (page_wr || guard_wr),
    .wdata_in    (wdata),
    .from_icp_in (from_icp),
    .relock_in   (erase_done),
    .state_out   (lock_state)
  );

  fpc_op_timer u_tmr (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .start_in (start),
    .load_in  (tmr_load),
    .busy_out (busy),
    .done_out (done)
  );

  assign page_pointer_next = page_wr ? wdata : page_pointer_reg;
  assign sector_write_guard_next = guard_wr ? sector_write_guard | wdata
                                            : sector_write_guard;

  // scope must outlive the relock that ends every erase
  assign scope_next = (erase_done && flash_cmd_reg.mass_erase) ? SCOPE_ALL :
                      (erase_done && !flash_cmd_reg.info &&
                       scope_reg != SCOPE_ALL) ? SCOPE_PAGE : scope_reg;

  // done bit set at port erase end, cleared at next port erase start
  assign icp_done_next = (erase_done && op_icp_reg) ? 1'b1 :
                         ((perase_go || merase_go) && from_icp) ? 1'b0 :
                         icp_done_reg;

  assign refused_next = (prog_bad || erase_bad) ? 1'b1 :
                        start ? 1'b0 : refused_reg;

  always_comb begin
    flash_cmd_next = flash_cmd_reg;
    if (done) begin
      flash_cmd_next = '0;
    end else if (prog_go) begin
      flash_cmd_next.prog  = 1'b1;
      flash_cmd_next.info  = prog_in.info;
      flash_cmd_next.addr  = prog_in.addr;
      flash_cmd_next.wdata = prog_in.data & flash_rdata_in;
    end else if (perase_go) begin
      flash_cmd_next.page_erase = 1'b1;
      flash_cmd_next.info       = sel_info;
      flash_cmd_next.addr       = {sel_page, {PAGE_ADDR_LSB{1'b0}}};
      flash_cmd_next.wdata      = ERASED_BYTE;
    end else if (merase_go) begin
      flash_cmd_next.mass_erase = 1'b1;
      flash_cmd_next.wdata      = ERASED_BYTE;
    end
  end

  // status answers reads of the command address
  assign rdata_next =
    !reg_rd_in ? reg_rdata_out :
    reg_req_in.addr == ADDR_CMD ?
      {1'b0, scope_reg, refused_reg, busy, lock_state} :
    reg_req_in.addr == ADDR_PAGE ? page_pointer_reg : 8'h00;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      page_pointer_reg   <= PAGE_RESET;
      sector_write_guard <= GUARD_RESET;
      scope_reg          <= SCOPE_NONE;
      mass_done_reg      <= 1'b0;
      icp_done_reg       <= 1'b0;
      refused_reg        <= 1'b0;
      op_icp_reg         <= 1'b0;
      flash_cmd_reg      <= '0;
      reg_rdata_out      <= 8'h00;
    end else begin
      page_pointer_reg   <= page_pointer_next;
      sector_write_guard <= sector_write_guard_next;
      scope_reg          <= scope_next;
      mass_done_reg      <= mass_done_reg ||
                            (erase_done && flash_cmd_reg.mass_erase);
      icp_done_reg       <= icp_done_next;
      refused_reg        <= refused_next;
      op_icp_reg         <= start ? (prog_go ? prog_in.in_circuit_prog_port : from_icp)
                                  : op_icp_reg;
      flash_cmd_reg      <= flash_cmd_next;
      reg_rdata_out      <= rdata_next;
    end
  end

  assign flash_cmd_out = flash_cmd_reg;
  // stall the CPU for its own operations
  assign cpu_stall_out = busy && !op_icp_reg;
  assign icp_status_out = {4'h0, icp_done_reg, 3'h0};
  assign ext_main_rd_block_out = prot_rw;
  assign ext_low_rd_block_out  = prot_low;

  localparam int PROG_WAIT = PROG_CYC;

  property prog_len_p;
    @(posedge clk_in) disable iff (!rst_n)
    prog_go |-> ##PROG_WAIT flash_cmd_out.prog ##1 !flash_cmd_out.prog;
  endproperty
  prog_timing_a: assert property (prog_len_p)
    else $error("program pulse length wrong");
  // stall ends with the operation so the CPU resumes
  cpu_stall_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (prog_go && !prog_in.in_circuit_prog_port) |-> ##PROG_WAIT cpu_stall_out ##1
    !cpu_stall_out)
    else $error("CPU stall length wrong");
  guard_sticky_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    !guard_wr |=> $stable(sector_write_guard))
    else $error("guard changed without a write");
  guard_or_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    guard_wr |=> sector_write_guard ==
                 ($past(sector_write_guard) | $past(wdata)))
    else $error("guard write not merged");
  guard_keep_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    ($past(sector_write_guard) & ~sector_write_guard) == 8'h00)
    else $error("guard bit lost");
  cpu_no_mass_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (cmd_wr && !from_icp) |=> !flash_cmd_out.mass_erase)
    else $error("CPU started a mass erase");
  guarded_cpu_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (prog_take && !prog_in.in_circuit_prog_port &&
     guarded(sector_write_guard, prog_in.addr[15:PAGE_ADDR_LSB]))
    |=> !flash_cmd_out.prog)
    else $error("guarded sector programmed by CPU");
  locked_idle_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (!unlocked && !busy) |=> !flash_cmd_out.prog &&
     !flash_cmd_out.page_erase && !flash_cmd_out.mass_erase)
    else $error("operation while locked");
  relock_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    erase_done |=> lock_state == ST_LOCKED)
    else $error("no relock after erase");
  icp_done_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (erase_done && op_icp_reg) |=> icp_status_out[ICP_DONE_BIT])
    else $error("port done bit not set");
  match_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (prog_go && !prog_in.info) |-> main_match)
    else $error("program outside selected page");
  info_cpu_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (prog_req_in && !busy && !prog_in.in_circuit_prog_port && prog_in.info) |=>
    !flash_cmd_out.prog)
    else $error("CPU reached info block");
  cmd_relock_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (cmd_wr && unlocked && wdata != CMD_PAGE_ERASE &&
     wdata != CMD_MASS_ERASE) |=> lock_state == ST_LOCKED)
    else $error("other command left controller unlocked");
  port_guard_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (cmd_wr && from_icp && unlocked && wdata == CMD_PAGE_ERASE &&
     !sel_info && ext_main_ok) |=> flash_cmd_out.page_erase)
    else $error("port page erase not started");
  status_read_a: assert property (
    @(posedge clk_in) disable iff (!rst_n)
    (reg_rd_in && reg_req_in.addr == ADDR_CMD) |=>
    reg_rdata_out[2:0] == $past(lock_state))
    else $error("status read lost lock state");

  unlock_c: cover property (@(posedge clk_in) disable iff (!rst_n)
    lock_state == ST_GOT_8C ##1 unlocked);
  perase_c: cover property (@(posedge clk_in) disable iff (!rst_n)
    perase_go);
  merase_c: cover property (@(posedge clk_in) disable iff (!rst_n)
    merase_go);
  guard_c: cover property (@(posedge clk_in) disable iff (!rst_n)
    guard_wr && wdata != 8'h00);
  prog_c: cover property (@(posedge clk_in) disable iff (!rst_n)
    prog_go);
endmodule

// file: fpc_pkg.sv
/*
 * Shared constants, states and carriers of the flash erase/program
 * controller. Assumes an 8-bit register port and a 10 MHz system clock.
 */
package fpc_pkg;
  localparam logic [7:0] ADDR_CMD       = 8'h00;
  localparam logic [7:0] ADDR_PAGE      = 8'h02;
  localparam logic [7:0] CMD_UNLOCK1    = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2    = 8'h8C;
  localparam logic [7:0] CMD_SEC_ARM    = 8'h5E;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] PAGE_INFO3     = 8'h83;
  localparam logic [7:0] PAGE_RESET     = 8'h00;
  localparam logic [7:0] GUARD_RESET    = 8'h00;
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;
  localparam int INFO_SEL_BIT     = 7;
  localparam int ICP_DONE_BIT     = 3;
  localparam int STAT_BUSY_BIT    = 3;
  localparam int STAT_REFUSED_BIT = 4;
  localparam int STAT_SCOPE_LSB   = 5;
  localparam int SECTOR_LSB       = 4;
  localparam int PAGE_ADDR_LSB    = 9;
  localparam int INFO_ADDR_LSB    = 6;
  localparam int TMR_W            = 17;
  localparam int CLK_PERIOD_NS    = 100;
  localparam int PROG_TIME_NS     = 30000;
  localparam int ERASE_TIME_NS    = 10000000;
  localparam int PROG_CYC  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_LOCKED, ST_GOT_PAGE, ST_GOT_73, ST_GOT_8C, ST_UNLOCKED, ST_SEC_ARMED
  } fpc_lock_t;

  typedef enum logic [1:0] {SCOPE_NONE, SCOPE_PAGE, SCOPE_ALL} fpc_scope_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       in_circuit_prog_port;
  } fpc_reg_wr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        info;
    logic        in_circuit_prog_port;
  } fpc_prog_req_t;

  typedef struct packed {
    logic        prog;
    logic        page_erase;
    logic        mass_erase;
    logic        info;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fpc_flash_cmd_t;
endpackage

// file: fpc_op_timer.sv
/*
 * Down counter that times one flash operation.
 * Assumes start_in is only pulsed while busy_out is low.
 */
`timescale 1ns/10ps
module fpc_op_timer
  import fpc_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             start_in,
  input  wire logic [TMR_W-1:0] load_in,
  output logic                  busy_out,
  output logic                  done_out
);
  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;

  assign cnt_next = start_in ? load_in :
                    (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
  assign busy_out = (cnt_reg != '0);
  assign done_out = (cnt_reg == {{(TMR_W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// file: fpc_unlock_seq.sv
/*
 * Lock state machine: unlock sequence and sector guard arming.
 * Assumes the caller presents writes only while no operation runs.
 */
`timescale 1ns/10ps
module fpc_unlock_seq
  import fpc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       cmd_wr_in,
  input  wire logic       page_wr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       from_icp_in,
  input  wire logic       relock_in,
  output fpc_lock_t       state_out
);
  fpc_lock_t  state_reg;
  fpc_lock_t  state_next;
  logic [7:0] first_page_reg;
  logic [7:0] first_page_next;

  assign first_page_next = (page_wr_in && state_reg == ST_LOCKED) ||
                           (page_wr_in && state_reg == ST_GOT_PAGE) ?
                           wdata_in : first_page_reg;
  assign state_out = state_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_LOCKED: begin
        if (page_wr_in) state_next = ST_GOT_PAGE;
        else if (cmd_wr_in && wdata_in == CMD_SEC_ARM)
          state_next = ST_SEC_ARMED;
      end
      ST_SEC_ARMED: begin
        if (page_wr_in) state_next = ST_LOCKED;
        else if (cmd_wr_in && wdata_in != CMD_SEC_ARM)
          state_next = ST_LOCKED;
      end
      ST_GOT_PAGE: begin
        if (cmd_wr_in)
          state_next = (wdata_in == CMD_UNLOCK1) ? ST_GOT_73 : ST_LOCKED;
      end
      ST_GOT_73: begin
        if (page_wr_in) state_next = ST_LOCKED;
        else if (cmd_wr_in)
          state_next = (wdata_in == CMD_UNLOCK2) ? ST_GOT_8C : ST_LOCKED;
      end
      ST_GOT_8C: begin
        if (page_wr_in)
          state_next = (wdata_in == first_page_reg) ? ST_UNLOCKED : ST_LOCKED;
        else if (cmd_wr_in) state_next = ST_LOCKED;
      end
      ST_UNLOCKED: begin
        if (cmd_wr_in && wdata_in != CMD_PAGE_ERASE &&
            wdata_in != CMD_MASS_ERASE) state_next = ST_LOCKED;
        else if (page_wr_in && !from_icp_in) state_next = ST_LOCKED;
      end
      default: state_next = ST_LOCKED;
    endcase
    if (relock_in) state_next = ST_LOCKED;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg      <= ST_LOCKED;
      first_page_reg <= PAGE_RESET;
    end else begin
      state_reg      <= state_next;
      first_page_reg <= first_page_next;
    end
  end
endmodule

// file: fpc_flash_model.sv
/*
 * Flash array model: 64K main bytes and one 64-byte info page.
 * Assumes the controller holds flash_cmd_out for a whole operation.
 */
`timescale 1ns/10ps
module fpc_flash_model
  import fpc_pkg::*;
(
  input  wire logic           clk_in,
  input  wire fpc_flash_cmd_t cmd_in,
  input  wire logic [15:0]    addr_in,
  input  wire logic           info_in,
  output logic [7:0]          rdata_out
);
  logic [7:0]     mem [0:65535];
  logic [7:0]     info_mem [0:63];
  fpc_flash_cmd_t cmd_d;
  initial begin
    cmd_d = '0;
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    foreach (info_mem[i]) info_mem[i] = ERASED_BYTE;
  end
  assign rdata_out = info_in ? info_mem[addr_in[5:0]] : mem[addr_in];
  // acts once, on the first cycle of each command
  always @(posedge clk_in) begin
    cmd_d <= cmd_in;
    if (cmd_in.prog && !cmd_d.prog) begin
      if (cmd_in.info) info_mem[cmd_in.addr[5:0]] &= cmd_in.wdata;
      else mem[cmd_in.addr] &= cmd_in.wdata;
    end
    // page erase, 512 main bytes or info page
    if (cmd_in.page_erase && !cmd_d.page_erase) begin
      if (cmd_in.info) foreach (info_mem[i]) info_mem[i] = ERASED_BYTE;
      else for (int i = 0; i < 512; i++)
        mem[{cmd_in.addr[15:9], i[8:0]}] = ERASED_BYTE;
    end
    // mass erase leaves the info page alone
    if (cmd_in.mass_erase && !cmd_d.mass_erase)
      foreach (mem[i]) mem[i] = ERASED_BYTE;
  end
endmodule

// file: testbench.sv
/*
 * Self-checking bench for the flash controller with an array model.
 * Assumes erase time shortened through ERASE_CYCLES.
 */
`timescale 1ns/10ps
module testbench
  import fpc_pkg::*;
;
  localparam int ECYC = 20;
  logic           clk_in, rstn_in, reg_wr_in, reg_rd_in, prog_req_in;
  logic           opt_rw_prot_in, opt_low_prot_in, cpu_stall_out;
  logic           main_blk, low_blk;
  logic           rd_seen, stall_seen, info_seen;
  fpc_reg_wr_t    reg_req_in;
  fpc_prog_req_t  prog_in;
  fpc_flash_cmd_t flash_cmd_out;
  logic [7:0]     reg_rdata_out, icp_status_out, flash_rdata_in, d1, d2;
  logic [15:0]    pa;
  logic [15:0]    exp_q [$];
  int             num_errors, compares, seed, n;

  fpc_flash_ctrl #(.ERASE_CYCLES(ECYC)) i_dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .prog_req_in(prog_req_in),
    .prog_in(prog_in), .opt_rw_prot_in(opt_rw_prot_in),
    .opt_low_prot_in(opt_low_prot_in), .flash_rdata_in(flash_rdata_in),
    .flash_cmd_out(flash_cmd_out), .cpu_stall_out(cpu_stall_out),
    .icp_status_out(icp_status_out), .ext_main_rd_block_out(main_blk),
    .ext_low_rd_block_out(low_blk));
  fpc_flash_model i_flash (
    .clk_in(clk_in), .cmd_in(flash_cmd_out), .addr_in(prog_in.addr),
    .info_in(prog_in.info), .rdata_out(flash_rdata_in));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("num_errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic in_circuit_prog_port);
    @(negedge clk_in);
    reg_wr_in = 1'b1;
    reg_req_in = '{addr: a, data: d, in_circuit_prog_port: in_circuit_prog_port};
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask

  // expected read value is queued with its mask
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    @(negedge clk_in);
    reg_rd_in = 1'b1;
    reg_req_in.addr = a;
    exp_q.push_back({m, e});
    @(negedge clk_in);
    reg_rd_in = 1'b0;
  endtask

  always @(posedge clk_in) rd_seen <= reg_rd_in;
  always @(negedge clk_in) begin
    logic [15:0] x;
    if (rd_seen === 1'b1) begin
      x = exp_q.pop_front();
      chk({8'h00, reg_rdata_out & x[15:8]}, {8'h00, x[7:0]});
    end
  end

  task automatic unlock(input logic [7:0] p, input logic in_circuit_prog_port);
    wr(ADDR_PAGE, p, in_circuit_prog_port);
    wr(ADDR_CMD, CMD_UNLOCK1, in_circuit_prog_port);
    wr(ADDR_CMD, CMD_UNLOCK2, in_circuit_prog_port);
    wr(ADDR_PAGE, p, in_circuit_prog_port);
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] d,
                      input logic inf);
    @(negedge clk_in);
    prog_req_in = 1'b1;
    prog_in = '{addr: a, data: d, info: inf, in_circuit_prog_port: 1'b0};
    @(negedge clk_in);
    prog_req_in = 1'b0;
  endtask

  // counts active command cycles over a window longer than any operation
  task automatic op(output int cyc);
    cyc = 0;
    stall_seen = 1'b0;
    info_seen = 1'b0;
    repeat (PROG_CYC + 10) begin
      if (flash_cmd_out.prog | flash_cmd_out.page_erase |
          flash_cmd_out.mass_erase) begin
        cyc++;
        stall_seen |= cpu_stall_out;
        info_seen |= flash_cmd_out.info;
      end
      @(negedge clk_in);
    end
  endtask

  initial begin
    #3000000;
    num_errors++;
    end_of_test();
  end

  initial begin
    seed = 33425;
    {num_errors, compares} = '0;
    {rstn_in, reg_wr_in, reg_rd_in, prog_req_in} = '0;
    reg_req_in = '0;
    prog_in = '0;
    opt_rw_prot_in = 1'b1;
    opt_low_prot_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    repeat (4) @(negedge clk_in);
    rd(ADDR_CMD, 8'hFF, 8'h00);
    rd(ADDR_PAGE, 8'hFF, PAGE_RESET);
    chk(main_blk, 1);
    chk(low_blk, 1);
    unlock(8'h10, 1'b1);
    wr(ADDR_CMD, CMD_PAGE_ERASE, 1'b1);
    op(n);
    chk(n, 0);
    rd(ADDR_CMD, 8'h10, 8'h10);
    wr(ADDR_CMD, CMD_MASS_ERASE, 1'b1);
    op(n);
    chk(n, ECYC);
    chk(icp_status_out[ICP_DONE_BIT], 1);
    chk(main_blk, 0);
    chk(low_blk, 0);
    rd(ADDR_CMD, 8'h07, 8'h00);
    unlock(PAGE_INFO3, 1'b1);
    wr(ADDR_CMD, CMD_PAGE_ERASE, 1'b1);
    op(n);
    chk({n[15:0]}, ECYC);
    chk(info_seen, 1);
    // guard sector 0, then try to clear it
    wr(ADDR_CMD, CMD_SEC_ARM, 1'b0);
    wr(ADDR_PAGE, 8'h01, 1'b0);
    wr(ADDR_CMD, CMD_SEC_ARM, 1'b0);
    wr(ADDR_PAGE, 8'h00, 1'b0);
    unlock(8'h05, 1'b0);
    rd(ADDR_CMD, 8'h07, 8'h04);
    wr(ADDR_CMD, CMD_PAGE_ERASE, 1'b0);
    op(n);
    chk(n, 0);
    rd(ADDR_CMD, 8'h10, 8'h10);
    wr(ADDR_CMD, CMD_MASS_ERASE, 1'b0);
    op(n);
    chk(n, 0);
    do d1 = 8'($random(seed));
    while (d1 inside {8'h95, 8'h63, 8'h73, 8'h8C, 8'h5E});
    wr(ADDR_CMD, d1, 1'b0);
    rd(ADDR_CMD, 8'h07, 8'h00);
    unlock(8'h05, 1'b1);
    wr(ADDR_CMD, CMD_PAGE_ERASE, 1'b1);
    op(n);
    chk(n, ECYC);
    chk(stall_seen, 0);
    unlock(8'h20, 1'b0);
    wr(ADDR_CMD, CMD_PAGE_ERASE, 1'b0);
    op(n);
    chk(n, ECYC);
    chk(stall_seen, 1);
    unlock(8'h20, 1'b0);
    pa = {7'h20, 9'($random(seed))};
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    prog(pa, d1, 1'b0);
    op(n);
    chk(n, PROG_CYC);
    chk(flash_rdata_in, d1);
    prog(pa, d2, 1'b0);
    op(n);
    chk(flash_rdata_in, d1 & d2);
    prog(pa, 8'h00, 1'b1);
    op(n);
    chk(n, 0);
    prog(16'h6000, d1, 1'b0);
    op(n);
    chk(n, 0);
    rd(ADDR_CMD, 8'h17, 8'h14);
    // misordered commands, then mismatched page writes
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CMD, 8'h00, 1'b0);
      wr(ADDR_PAGE, 8'h30, 1'b0);
      wr(ADDR_CMD, k ? CMD_UNLOCK1 : CMD_UNLOCK2, 1'b0);
      wr(ADDR_CMD, k ? CMD_UNLOCK2 : CMD_UNLOCK1, 1'b0);
      wr(ADDR_PAGE, 8'h30 + 8'(k), 1'b0);
      // k=0: misorder relocks, the last page write restarts at step one; k=1: the mismatched page write relocks
      rd(ADDR_CMD, 8'h07, k ? 8'h00 : 8'h01);
    end
    end_of_test();
  end
endmodule
